/* hw/frame_tag_pkg.sv */
// Overview of operation
// - extended identifier is 29 bits spread over the four tag bytes
// - extended identifier bit 28 goes out first, then lower bits descending
// - smallest identifier wins; a sent 1 read back as 0 loses
// - standard identifier is 11 bits, bit 10 sent first
// - received substitute remote request bit is stored as sampled
// - extension bit 0 sends 11-bit identifier, 1 sends 29-bit identifier
// - received extension bit is stored as it arrived
// - remote request bit is sent as held in the buffer
// - received remote request bit is stored, 1 meaning remote frame
// - extended byte 1 holds id 20..18, srr, ide, id 17..15
// - extended byte 3 holds identifier bits 6..0 then remote request bit
// - standard byte 0 holds identifier bits 10 down to 3
// - standard byte 1 holds id 2..0, remote request, extension bit 0
// - unused standard bits read back whatever was last written to them
// - tag bytes have no reset value, held in uninitialised storage
package frame_tag_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   // register indices; byte address is four times the index
   localparam logic [3:0] IDX_TAG_0 = 4'h0;
   localparam logic [3:0] IDX_TAG_3 = 4'h3;
   localparam logic [3:0] IDX_RX_TAG_0 = 4'h4;
   localparam logic [3:0] IDX_RX_TAG_3 = 4'h7;
   localparam logic [3:0] IDX_CTRL = 4'h8;
   // control and status register fields
   localparam int unsigned CTRL_TX_EMPTY = 0;
   localparam int unsigned CTRL_RX_FULL = 1;
   localparam int unsigned CTRL_TX_SEL = 2;
   localparam logic TX_EMPTY_RST = 1'b1;
   localparam logic RX_FULL_RST = 1'b0;
   localparam logic TX_SEL_RST = 1'b0;
   // header word is tag byte 0 in bits 31..24 down to byte 3 in 7..0
   localparam int unsigned HDR_POS_IDE = 19;
   localparam logic [5:0] HDR_TOP = 6'h1f;
   localparam logic [5:0] HDR_LEN_STD = 6'h0d;
   localparam logic [5:0] HDR_LEN_EXT = 6'h20;
   localparam logic [5:0] HDR_IDE_CNT = 6'h0c;
endpackage

/* hw/frame_tag_store.sv */
`timescale 1ns/100ps
module frame_tag_store
(
   // clock
   input wire logic ref_clk,
   // byte write
   input wire logic wr_byte_en,
   input wire logic [1:0] wr_byte_idx,
   input wire logic [7:0] wr_byte,
   // whole header write
   input wire logic wr_word_en,
   input wire logic [31:0] wr_word,
   // contents
   output logic [31:0] word
);
   import frame_tag_pkg::*;

   typedef struct packed
   {
      logic [31:0] word;
   } store_type;

   store_type state;
   store_type next_state;

   always_comb
   begin
      next_state = state;
      if (wr_word_en)
      begin
         next_state.word = wr_word;
      end
      else if (wr_byte_en)
      begin
         next_state.word[8 * (3 - wr_byte_idx) +: 8] = wr_byte;
      end
   end

   // no reset: contents are undefined until written
   always_ff @(posedge ref_clk)
   begin
      state <= next_state;
   end

   assign word = state.word;
endmodule

/* hw/frame_tag_buffers.sv */
`timescale 1ns/100ps
module frame_tag_buffers
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [frame_tag_pkg::ADDR_W-1:0] paddr,
   input wire logic [frame_tag_pkg::DATA_W-1:0] pwdata,
   output logic [frame_tag_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // protocol engine bit timing
   input wire logic bit_tick,
   input wire logic bus_bit,
   // protocol engine transmit side
   input wire logic tx_start,
   input wire logic tx_frame_ok,
   output logic tx_bit,
   output logic tx_hdr_busy,
   output logic tx_hdr_end,
   output logic tx_arb_lost,
   output logic transmit_slot_empty_flag,
   // protocol engine receive side
   input wire logic rx_start,
   input wire logic rx_frame_ok,
   output logic rx_hdr_ok,
   output logic receive_full_flag
);
   import frame_tag_pkg::*;

   typedef struct packed
   {
      logic [DATA_W-1:0] prdata;
      logic pslverr;
      logic tx_empty;
      logic tx_sel;
      logic tx_active;
      logic [5:0] tx_cnt;
      logic tx_bit;
      logic tx_hdr_end;
      logic tx_arb_lost;
      logic rx_full;
      logic rx_pend;
      logic rx_active;
      logic rx_hdr_ok;
      logic [5:0] rx_cnt;
      logic [31:0] rx_hdr;
   } ctrl_type;

   ctrl_type state;
   ctrl_type next_state;

   logic [31:0] tx_word;
   logic [31:0] rx_word;
   logic tx_wr_en;
   logic [1:0] tx_wr_idx;
   logic rx_wr_all;
   logic setup;
   logic access;
   logic aligned;
   logic [3:0] idx;
   logic tx_ok;
   logic [5:0] hdr_len;
   logic [5:0] tx_cnt_inc;
   logic [5:0] rx_cnt_inc;

   frame_tag_store tx_store
   (
      .ref_clk(ref_clk),
      .wr_byte_en(tx_wr_en),
      .wr_byte_idx(tx_wr_idx),
      .wr_byte(pwdata[7:0]),
      .wr_word_en(1'b0),
      .wr_word(32'h0000_0000),
      .word(tx_word)
   );

   frame_tag_store rx_store
   (
      .ref_clk(ref_clk),
      .wr_byte_en(1'b0),
      .wr_byte_idx(2'h0),
      .wr_byte(8'h00),
      .wr_word_en(rx_wr_all),
      .wr_word(state.rx_hdr),
      .word(rx_word)
   );

   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign idx = paddr[5:2];
   assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:6] == '0);
   assign tx_ok = state.tx_empty & state.tx_sel;
   // extension bit picks 13 or 32 header bits
   assign hdr_len = tx_word[HDR_POS_IDE] ? HDR_LEN_EXT : HDR_LEN_STD;
   assign tx_cnt_inc = state.tx_cnt + 6'h01;
   assign rx_cnt_inc = state.rx_cnt + 6'h01;

   always_comb
   begin
      next_state = state;
      tx_wr_en = 1'b0;
      tx_wr_idx = idx[1:0];
      rx_wr_all = 1'b0;
      next_state.tx_hdr_end = 1'b0;
      next_state.tx_arb_lost = 1'b0;
      next_state.rx_pend = 1'b0;

      // setup phase: decode and latch read data and error
      if (setup)
      begin
         next_state.prdata = '0;
         next_state.pslverr = 1'b0;
         if (!aligned)
         begin
            next_state.pslverr = 1'b1;
         end
         else if (idx <= IDX_TAG_3)
         begin
            if (tx_ok)
            begin
               // raw bytes, unused standard bits included
               next_state.prdata[7:0] = tx_word[8 * (3 - idx[1:0]) +: 8];
            end
            else
            begin
               next_state.pslverr = 1'b1;
            end
         end
         else if (idx >= IDX_RX_TAG_0 && idx <= IDX_RX_TAG_3)
         begin
            if (pwrite || !state.rx_full)
            begin
               next_state.pslverr = 1'b1;
            end
            else
            begin
               next_state.prdata[7:0] = rx_word[8 * (3 - idx[1:0]) +: 8];
            end
         end
         else if (idx == IDX_CTRL)
         begin
            next_state.prdata[CTRL_TX_EMPTY] = state.tx_empty;
            next_state.prdata[CTRL_RX_FULL] = state.rx_full;
            next_state.prdata[CTRL_TX_SEL] = state.tx_sel;
         end
         else
         begin
            next_state.pslverr = 1'b1;
         end
      end

      // access phase: writes take effect here
      if (access && pwrite && !state.pslverr)
      begin
         if (idx <= IDX_TAG_3)
         begin
            // bytes land in the layouts of both formats
            tx_wr_en = 1'b1;
         end
         else if (idx == IDX_CTRL)
         begin
            next_state.tx_sel = pwdata[CTRL_TX_SEL];
            if (pwdata[CTRL_TX_EMPTY])
            begin
               next_state.tx_empty = 1'b0;
            end
            if (pwdata[CTRL_RX_FULL])
            begin
               next_state.rx_full = 1'b0;
            end
         end
      end

      // transmit header serializer, msb of byte 0 first
      if (tx_start && !state.tx_empty && !state.tx_active)
      begin
         next_state.tx_active = 1'b1;
         next_state.tx_cnt = 6'h00;
         next_state.tx_bit = tx_word[31];
      end
      else if (state.tx_active && bit_tick)
      begin
         if (state.tx_bit && !bus_bit)
         begin
            // recessive lost to dominant: lower identifier wins
            next_state.tx_active = 1'b0;
            next_state.tx_arb_lost = 1'b1;
            next_state.tx_bit = 1'b1;
         end
         else if (tx_cnt_inc == hdr_len)
         begin
            next_state.tx_active = 1'b0;
            next_state.tx_hdr_end = 1'b1;
            next_state.tx_bit = 1'b1;
         end
         else
         begin
            // id, srr, ide and rtr go out as held
            next_state.tx_cnt = tx_cnt_inc;
            next_state.tx_bit = tx_word[5'(HDR_TOP - tx_cnt_inc)];
         end
      end
      // engine completion wins over a software request
      if (tx_frame_ok)
      begin
         next_state.tx_empty = 1'b1;
         next_state.tx_active = 1'b0;
      end

      // receive header capture in arrival order
      if (rx_start)
      begin
         next_state.rx_active = 1'b1;
         next_state.rx_hdr_ok = 1'b0;
         next_state.rx_cnt = 6'h00;
      end
      else if (state.rx_active && bit_tick)
      begin
         next_state.rx_hdr[5'(HDR_TOP - state.rx_cnt)] = bus_bit;
         next_state.rx_cnt = rx_cnt_inc;
         if ((state.rx_cnt == HDR_IDE_CNT && !bus_bit)
            || rx_cnt_inc == HDR_LEN_EXT)
         begin
            next_state.rx_active = 1'b0;
            next_state.rx_hdr_ok = 1'b1;
         end
      end
      // header is stored first, the full flag follows a cycle later
      if (rx_frame_ok && state.rx_hdr_ok && !state.rx_full)
      begin
         rx_wr_all = 1'b1;
         next_state.rx_pend = 1'b1;
         next_state.rx_hdr_ok = 1'b0;
      end
      if (state.rx_pend)
      begin
         next_state.rx_full = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= '0;
         state.tx_empty <= TX_EMPTY_RST;
         state.rx_full <= RX_FULL_RST;
         state.tx_sel <= TX_SEL_RST;
         state.tx_bit <= 1'b1;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign prdata = state.prdata;
   assign pready = access;
   assign pslverr = access & state.pslverr;
   assign tx_bit = state.tx_bit;
   assign tx_hdr_busy = state.tx_active;
   assign tx_hdr_end = state.tx_hdr_end;
   assign tx_arb_lost = state.tx_arb_lost;
   assign transmit_slot_empty_flag = state.tx_empty;
   assign rx_hdr_ok = state.rx_hdr_ok;
   assign receive_full_flag = state.rx_full;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   chk_tx_first_bit: assert property (
      tx_start && !state.tx_empty && !state.tx_active && !tx_frame_ok
      |=> tx_hdr_busy && tx_bit == tx_word[31])
      else $error("first header bit is not tag byte 0 bit 7");

   chk_tx_bit_order: assert property (
      state.tx_active && bit_tick && !(state.tx_bit && !bus_bit)
      && tx_cnt_inc != hdr_len && !tx_frame_ok
      |=> tx_bit == tx_word[5'(HDR_TOP - state.tx_cnt)])
      else $error("header bit sent out of order");

   chk_tx_hdr_len: assert property (
      tx_hdr_end |-> $past(state.tx_cnt) ==
      ($past(tx_word[HDR_POS_IDE]) ? HDR_TOP : HDR_LEN_STD - 6'h01))
      else $error("header length does not match extension bit");

   chk_tx_arb_loss: assert property (
      state.tx_active && bit_tick && state.tx_bit && !bus_bit
      |=> tx_arb_lost && !tx_hdr_busy ##1 !tx_arb_lost)
      else $error("lost arbitration not reported as one pulse");

   chk_tx_lock: assert property (
      tx_wr_en |-> state.tx_empty && state.tx_sel && access)
      else $error("transmit bytes written while locked");

   chk_tx_empty_set: assert property (
      tx_frame_ok |=> transmit_slot_empty_flag && !tx_hdr_busy)
      else $error("frame completion did not set empty flag");

   chk_rx_store_first: assert property (
      $rose(receive_full_flag) |-> $past(rx_wr_all, 2))
      else $error("receive full raised before header stored");

   chk_rx_capture: assert property (
      rx_wr_all |=> rx_word == $past(state.rx_hdr) ##1 receive_full_flag)
      else $error("received header not stored as sampled");

   chk_rx_read_gate: assert property (
      setup && aligned && idx >= IDX_RX_TAG_0 && idx <= IDX_RX_TAG_3
      && !state.rx_full |=> state.pslverr && prdata == '0)
      else $error("receive bytes readable while not full");
endmodule

/* tb/can_node_model.sv */
`timescale 1ns/100ps
module can_node_model
(
   // clock
   input wire logic ref_clk,
   // from the buffers
   input wire logic tx_bit,
   input wire logic tx_hdr_end,
   input wire logic tx_arb_lost,
   input wire logic rx_hdr_ok,
   // to the buffers
   output logic bit_tick,
   output logic node_bit,
   output logic tx_start,
   output logic tx_frame_ok,
   output logic rx_start,
   output logic rx_frame_ok
);
   initial
   begin
      {bit_tick, tx_start, tx_frame_ok, rx_start, rx_frame_ok} = 5'h00;
      node_bit = 1'b1;
   end

   // clock a header out; this node pulls dominant at bit lose_at
   task automatic send(input int lose_at, input int gap,
      output logic [31:0] got, output int n);
      got = 32'h0;
      n = 0;
      tx_start <= 1'b1;
      @(posedge ref_clk);
      tx_start <= 1'b0;
      do
      begin
         repeat (gap) @(posedge ref_clk);
         node_bit <= (n == lose_at) ? 1'b0 : 1'b1;
         bit_tick <= 1'b1;
         @(posedge ref_clk);
         got = {got[30:0], tx_bit};
         n++;
         bit_tick <= 1'b0;
         node_bit <= 1'b1;
         @(posedge ref_clk);
      end
      while (tx_hdr_end !== 1'b1 && tx_arb_lost !== 1'b1 && n < 40);
   endtask

   task automatic frame_sent;
      tx_frame_ok <= 1'b1;
      @(posedge ref_clk);
      tx_frame_ok <= 1'b0;
      @(posedge ref_clk);
   endtask

   // bus idles recessive between bits and frames
   task automatic recv(input logic [31:0] h, input int n, input int gap);
      rx_start <= 1'b1;
      @(posedge ref_clk);
      rx_start <= 1'b0;
      for (int i = 0; i < n; i++)
      begin
         node_bit <= h[31-i];
         bit_tick <= 1'b1;
         @(posedge ref_clk);
         bit_tick <= 1'b0;
         node_bit <= 1'b1;
         repeat (gap + 1) @(posedge ref_clk);
      end
      do @(posedge ref_clk); while (rx_hdr_ok !== 1'b1);
      rx_frame_ok <= 1'b1;
      @(posedge ref_clk);
      rx_frame_ok <= 1'b0;
      @(posedge ref_clk);
   endtask
endmodule

/* tb/can_buffer_identifier_mapping_bench.sv */
`timescale 1ns/100ps
module can_buffer_identifier_mapping_bench;
   import frame_tag_pkg::*;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd_q, got;
   logic pready, pslverr, err_q, bit_tick, node_bit, bus_bit;
   logic tx_start, tx_frame_ok, rx_start, rx_frame_ok, rx_hdr_ok;
   logic tx_bit, tx_hdr_busy, tx_hdr_end, tx_arb_lost;
   logic transmit_slot_empty_flag, receive_full_flag;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;

   always #4 ref_clk = ~ref_clk;
   assign bus_bit = tx_bit & node_bit; // wired bus, dominant zero wins

   frame_tag_buffers u_frame_tag_buffers (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bit_tick(bit_tick), .bus_bit(bus_bit),
      .tx_start(tx_start), .tx_frame_ok(tx_frame_ok), .tx_bit(tx_bit),
      .tx_hdr_busy(tx_hdr_busy), .tx_hdr_end(tx_hdr_end),
      .tx_arb_lost(tx_arb_lost),
      .transmit_slot_empty_flag(transmit_slot_empty_flag),
      .rx_start(rx_start), .rx_frame_ok(rx_frame_ok),
      .rx_hdr_ok(rx_hdr_ok), .receive_full_flag(receive_full_flag));

   can_node_model u_can_node_model (.ref_clk(ref_clk), .tx_bit(tx_bit),
      .tx_hdr_end(tx_hdr_end), .tx_arb_lost(tx_arb_lost),
      .rx_hdr_ok(rx_hdr_ok), .bit_tick(bit_tick), .node_bit(node_bit),
      .tx_start(tx_start), .tx_frame_ok(tx_frame_ok),
      .rx_start(rx_start), .rx_frame_ok(rx_frame_ok));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [3:0] idx,
      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {6'h00, idx, 2'h0};
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   function automatic logic [31:0] hdr(input logic ext,
      input logic [28:0] id, input logic srr, input logic rtr);
      if (ext)
         return {id[28:21], id[20:18], srr, 1'b1, id[17:15], id[14:7],
            id[6:0], rtr}; // extended layout
      return {id[10:3], id[2:0], rtr, 1'b0, 19'h0}; // standard
   endfunction

   task automatic tally_and_finish;
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         tally_and_finish;
      end
   end

   initial
   begin
      logic [31:0] h, m;
      logic [28:0] id;
      logic ext;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      apb(1'b0, IDX_CTRL, 32'h0);
      check(rd_q[2:0], 3'h1); // empty, not full, unselected
      apb(1'b1, IDX_TAG_0, 32'h5a);
      check(err_q, 1'b1); // unselected buffer refused
      apb(1'b0, IDX_RX_TAG_0, 32'h0);
      check(err_q, 1'b1); // nothing received yet
      apb(1'b1, IDX_RX_TAG_3, 32'h0);
      check(err_q, 1'b1); // receive bytes read only
      apb(1'b0, 4'h9, 32'h0);
      check(err_q, 1'b1); // unmapped word
      apb(1'b1, IDX_CTRL, 32'h4);
      for (int c = 0; c < 4; c++)
      begin
         ext = (c < 2);
         id = ext ? 29'h0b5c3e71 + 29'(c) : 29'h5a3 + 29'(c);
         h = hdr(ext, id, 1'b1, c[0]); // recessive substitute bit
         for (int b = 0; b < 4; b++)
            apb(1'b1, IDX_TAG_0 + 4'(b), {24'h0, h[31-8*b -: 8]});
         for (int b = 0; b < 4; b++)
         begin
            apb(1'b0, IDX_TAG_0 + 4'(b), 32'h0);
            check(rd_q[7:0], h[31-8*b -: 8]);
         end
         apb(1'b1, IDX_CTRL, 32'h5);
         check(transmit_slot_empty_flag, 1'b0);
         apb(1'b0, IDX_TAG_0, 32'h0);
         check(err_q, 1'b1); // pending buffer locked
         if (c == 0)
         begin
            u_can_node_model.send(3, 0, got, n);
            check(n, 4); // lost on a dominant bit
            check(tx_hdr_busy, 1'b0);
         end
         u_can_node_model.send(-1, c, got, n);
         check(n, ext ? 32 : 13); // header length by format
         check(got, ext ? h : {19'h0, h[31:19]}); // msb first
         check(tx_hdr_busy, 1'b0);
         u_can_node_model.frame_sent;
         apb(1'b0, IDX_CTRL, 32'h0);
         check(rd_q[0], 1'b1); // sent frame frees the buffer
         check(transmit_slot_empty_flag, 1'b1);
         m = ext ? 32'hffffffff : 32'hfff80000;
         h = hdr(ext, id + 29'h3, c[0], c[0]);
         u_can_node_model.recv(h, ext ? 32 : 13, c);
         apb(1'b0, IDX_CTRL, 32'h0);
         check(rd_q[1], 1'b1); // full after the header is stored
         check(receive_full_flag, 1'b1);
         for (int b = 0; b < 4; b++)
         begin
            apb(1'b0, IDX_RX_TAG_0 + 4'(b), 32'h0);
            check(rd_q[7:0] & m[31-8*b -: 8], h[31-8*b -: 8] &
               m[31-8*b -: 8]);
         end
         apb(1'b1, IDX_CTRL, 32'h6);
         check(receive_full_flag, 1'b0);
      end
      tally_and_finish;
   end
endmodule
